// >>> rtl/rtu_decode.sv
// rtu_decode: combinational recogniser for the three return words.
// assumes the word at its input is a fully fetched instruction.
`timescale 1ns/1ps
module rtu_decode (
  input  wire logic [13:0]          insn_i,
  output rtu_pkg::rtu_dec_type      dec_o
);

  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  // plain, interrupt and literal returns; none takes an operand word
  always_comb begin
    dec_o      = '0;
    dec_o.lit  = insn_i[7:0];
    if (insn_i == rtu_pkg::OPC_RETURN) begin
      dec_o.hit  = 1'b1;
      dec_o.kind = rtu_pkg::RTU_K_PLAIN;
    end else if (insn_i == rtu_pkg::OPC_RETFROMIRQ) begin
      dec_o.hit  = 1'b1;
      dec_o.kind = rtu_pkg::RTU_K_IRQ;
    end else if (insn_i[13:rtu_pkg::RETLIT_HI_POS] == rtu_pkg::OPC_RETLIT_HI) begin
      dec_o.hit  = 1'b1;
      dec_o.kind = rtu_pkg::RTU_K_LIT;
    end
  end

endmodule

// >>> rtl/rtu_pkg.sv
// rtu_pkg: constants, encodings and carrier types for the return instruction unit.
// assumes a 14-bit instruction word and a 13-bit program counter in the core around it.
package rtu_pkg;

  // ---------------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------------
  localparam int unsigned INSN_W = 14;
  localparam int unsigned PC_W   = 13;
  localparam int unsigned DATA_W = 8;

  // ---------------------------------------------------------------------------
  // encodings of the three return forms (one program word each)
  // ---------------------------------------------------------------------------
  localparam logic [13:0] OPC_RETURN     = 14'h0008;
  localparam logic [13:0] OPC_RETFROMIRQ = 14'h0009;
  localparam logic [5:0]  OPC_RETLIT_HI  = 6'h0D;  // top six bits, low eight hold k
  localparam int unsigned RETLIT_HI_POS  = 8;

  // ---------------------------------------------------------------------------
  // interrupt control register layout, vectors, timing
  // ---------------------------------------------------------------------------
  localparam int unsigned GLOBAL_EN_POS = 7;
  localparam logic [7:0]  ICR_RESET    = 8'h00;
  localparam logic [7:0]  W_RESET      = 8'h00;
  localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
  localparam logic [12:0] PC_RESET     = 13'h0000;
  localparam logic [1:0]  RET_CYCLES   = 2'h2;

  // one-hot sequencer state, and the kind of return being carried out
  typedef enum logic [3:0] {
    RTU_IDLE = 4'b0001,
    RTU_POP  = 4'b0010,
    RTU_LOAD = 4'b0100,
    RTU_WAKE = 4'b1000
  } rtu_state_type;

  typedef enum logic [1:0] {
    RTU_K_PLAIN = 2'h0,
    RTU_K_IRQ   = 2'h1,
    RTU_K_LIT   = 2'h2
  } rtu_kind_type;

  // decoded view of one instruction word
  typedef struct packed {
    logic        hit;
    logic [1:0]  kind;
    logic [7:0]  lit;
  } rtu_dec_type;

  // outputs towards the core
  typedef struct packed {
    logic        pc_load;
    logic [12:0] pc;
    logic        pop;
    logic        busy;
    logic [7:0]  w;
    logic [7:0]  icr;
    logic        wake;
  } rtu_out_type;

endpackage

// >>> rtl/rtu_return_unit.sv
// rtu_return_unit: carries out the return forms and the resume point after wake-up.
// assumes the core presents an instruction with insn_valid_i for one cycle, holds
// the return stack outside and supplies its top; power-down entry is outside.
//
// Operation
// - the interrupt return pops the stack and loads the pc from its top.
// - the interrupt return sets the global enable, bit 7 of the control register.
// - the interrupt return is one word with no operand and takes exactly two cycles.
// - the literal return loads the accumulator with its 8-bit operand.
// - the literal return also loads the pc from the stack top and takes two cycles.
// - the plain return pops into the pc in two cycles, leaving enable and accumulator.
// - after wake-up the pc goes to 0004h if interrupts are enabled, else runs on in line.
// - an enabled flag set during or after the sleep word wakes the core once it completes.
`timescale 1ns/1ps
module rtu_return_unit (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        insn_valid_i,
  input  wire logic [13:0] insn_i,
  input  wire logic [12:0] stack_top_i,
  input  wire logic [12:0] pc_next_i,
  input  wire logic        sleeping_i,
  input  wire logic        sleep_done_i,
  input  wire logic        irq_pending_i,
  input  wire logic        icr_wr_i,
  input  wire logic [7:0]  icr_wdata_i,
  output logic             pc_load_o,
  output logic [12:0]      pc_o,
  output logic             stack_pop_o,
  output logic             busy_o,
  output logic [7:0]       accum_o,
  output logic [7:0]       interrupt_control_reg_o,
  output logic             wake_o
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    rtu_pkg::rtu_state_type st;
    logic [1:0]             kind;
    rtu_pkg::rtu_out_type   o;
  } rtu_regs_type;

  rtu_regs_type         s_q;
  rtu_regs_type         s_d;
  rtu_pkg::rtu_dec_type dec;

  rtu_decode u_dec (
    .insn_i (insn_i),
    .dec_o  (dec)
  );

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  // cycle 1 pops and loads, cycle 2 is the flushed slot; wake resolves the resume point
  always_comb begin
    s_d            = s_q;
    s_d.o.pc_load  = 1'b0;
    s_d.o.pop      = 1'b0;
    s_d.o.wake     = 1'b0;
    if (icr_wr_i) begin
      s_d.o.icr = icr_wdata_i;
    end
    unique case (s_q.st)
      rtu_pkg::RTU_IDLE: begin
        if (sleeping_i && sleep_done_i && irq_pending_i) begin
          s_d.st     = rtu_pkg::RTU_WAKE;
          s_d.o.busy = 1'b1;
        end else if (insn_valid_i && dec.hit) begin
          s_d.st        = rtu_pkg::RTU_POP;
          s_d.kind      = dec.kind;
          s_d.o.busy    = 1'b1;
          s_d.o.pop     = 1'b1;
          s_d.o.pc_load = 1'b1;
          s_d.o.pc      = stack_top_i;
          if (dec.kind == rtu_pkg::RTU_K_LIT) begin
            s_d.o.w = dec.lit;
          end
          if (dec.kind == rtu_pkg::RTU_K_IRQ) begin
            s_d.o.icr[rtu_pkg::GLOBAL_EN_POS] = 1'b1;
          end
        end
      end
      rtu_pkg::RTU_POP: begin
        s_d.st = rtu_pkg::RTU_LOAD;
      end
      rtu_pkg::RTU_LOAD: begin
        s_d.st     = rtu_pkg::RTU_IDLE;
        s_d.o.busy = 1'b0;
      end
      rtu_pkg::RTU_WAKE: begin
        s_d.st        = rtu_pkg::RTU_IDLE;
        s_d.o.busy    = 1'b0;
        s_d.o.wake    = 1'b1;
        s_d.o.pc_load = 1'b1;
        s_d.o.pc      = s_q.o.icr[rtu_pkg::GLOBAL_EN_POS] ?
                        rtu_pkg::IRQ_VECTOR : pc_next_i;
      end
      default: begin
        s_d.st     = rtu_pkg::RTU_IDLE;
        s_d.o.busy = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_q.st   <= rtu_pkg::RTU_IDLE;
      s_q.kind <= 2'h0;
      s_q.o    <= '{pc_load: 1'b0, pc: rtu_pkg::PC_RESET, pop: 1'b0, busy: 1'b0,
                    w: rtu_pkg::W_RESET, icr: rtu_pkg::ICR_RESET, wake: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign pc_load_o               = s_q.o.pc_load;
  assign pc_o                    = s_q.o.pc;
  assign stack_pop_o             = s_q.o.pop;
  assign busy_o                  = s_q.o.busy;
  assign accum_o                 = s_q.o.w;
  assign interrupt_control_reg_o = s_q.o.icr;
  assign wake_o                  = s_q.o.wake;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  sequence ret_taken_s;
    insn_valid_i && dec.hit && !(sleeping_i && sleep_done_i && irq_pending_i)
      && s_q.st == rtu_pkg::RTU_IDLE;
  endsequence

  sequence two_busy_s;
    busy_o [*2] ##1 !busy_o;
  endsequence

  irq_pop_load_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ret_taken_s and (dec.kind == rtu_pkg::RTU_K_IRQ) |=>
      stack_pop_o && pc_load_o && pc_o == $past(stack_top_i))
    else $error("interrupt return did not load pc from stack top");

  irq_sets_en_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ret_taken_s and (dec.kind == rtu_pkg::RTU_K_IRQ) |=>
      interrupt_control_reg_o[7])
    else $error("interrupt return left global enable clear");

  ret_length_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ret_taken_s |=> two_busy_s)
    else $error("return did not take its fixed length");

  lit_load_w_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ret_taken_s and (dec.kind == rtu_pkg::RTU_K_LIT) |=> accum_o == $past(insn_i[7:0]))
    else $error("literal return did not load accumulator");

  lit_pop_pc_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ret_taken_s and (dec.kind == rtu_pkg::RTU_K_LIT) |=>
      pc_load_o && stack_pop_o ##1 !pc_load_o)
    else $error("literal return pc load wrong");

  plain_keeps_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ret_taken_s and (dec.kind == rtu_pkg::RTU_K_PLAIN) && !icr_wr_i |=>
      $stable(accum_o) && $stable(interrupt_control_reg_o) && stack_pop_o)
    else $error("plain return disturbed accumulator or enable");

  wake_vector_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wake_o |-> pc_load_o &&
      (pc_o == ($past(interrupt_control_reg_o[7]) ? 13'h0004 : $past(pc_next_i))))
    else $error("wake-up resume point wrong");

  wake_follows_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_q.st == rtu_pkg::RTU_IDLE && sleeping_i && sleep_done_i && irq_pending_i
      |=> ##1 wake_o)
    else $error("pending interrupt did not wake the core");

endmodule

// >>> test/tb_top.sv
// tb_top: self-checking bench for the return instruction unit.
// assumes rtu_pkg and rtu_return_unit are compiled first; inputs move on falling edges.
`timescale 1ns/1ps
module tb_top;
  // ---------------------------------------------------------------------------
  // signals and bench state
  // ---------------------------------------------------------------------------
  logic        clk_i         = 1'b0;
  logic        rst_b_i       = 1'b0;
  logic        insn_valid_i  = 1'b0;
  logic [13:0] insn_i        = 14'h0000;
  logic [12:0] stack_top_i   = 13'h0000;
  logic [12:0] pc_next_i     = 13'h0000;
  logic        sleeping_i    = 1'b0;
  logic        sleep_done_i  = 1'b0;
  logic        irq_pending_i = 1'b0;
  logic        icr_wr_i      = 1'b0;
  logic [7:0]  icr_wdata_i   = 8'h00;
  logic        pc_load_o;
  logic        stack_pop_o;
  logic        busy_o;
  logic        wake_o;
  logic [12:0] pc_o;
  logic [7:0]  accum_o;
  logic [7:0]  interrupt_control_reg_o;
  logic [31:0] lfsr_q        = 32'hE1E819DE;
  logic [13:0] rnd_w;
  logic [7:0]  exp_acc       = 8'h00;
  logic [7:0]  exp_icr       = 8'h00;
  int          err_total     = 0;
  int          n_compared    = 0;

  // free-running 250 MHz clock
  always #2 clk_i = ~clk_i;

  rtu_return_unit i_rtu_return_unit (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .insn_valid_i(insn_valid_i), .insn_i(insn_i),
    .stack_top_i(stack_top_i), .pc_next_i(pc_next_i), .sleeping_i(sleeping_i),
    .sleep_done_i(sleep_done_i), .irq_pending_i(irq_pending_i), .icr_wr_i(icr_wr_i),
    .icr_wdata_i(icr_wdata_i), .pc_load_o(pc_load_o), .pc_o(pc_o), .stack_pop_o(stack_pop_o),
    .busy_o(busy_o), .accum_o(accum_o), .interrupt_control_reg_o(interrupt_control_reg_o),
    .wake_o(wake_o));

  // ---------------------------------------------------------------------------
  // expectation helpers and compares
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // kind of a word: 0 none, 1 plain, 2 interrupt return, 3 literal return
  function automatic int kind_of(input logic [13:0] w);
    if (w === rtu_pkg::OPC_RETURN) return 1;
    if (w === rtu_pkg::OPC_RETFROMIRQ) return 2;
    if (w[13:8] === rtu_pkg::OPC_RETLIT_HI) return 3;
    return 0;
  endfunction

  task automatic chk_pc(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: pc got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: flag got %h expected %h", $time, got, exp);
    end
  endtask

  // ---------------------------------------------------------------------------
  // one issued word, optional same-cycle control write, busy walk
  // ---------------------------------------------------------------------------
  task automatic do_ret(input logic [13:0] w, input logic [12:0] top, input logic wr,
                        input logic [7:0] d);
    int k;
    k = kind_of(w);
    insn_valid_i = 1'b1;
    insn_i = w;
    stack_top_i = top;
    icr_wr_i = wr;
    icr_wdata_i = d;
    @(negedge clk_i);
    // a second return held while busy must be dropped
    insn_valid_i = (k != 0);
    insn_i = rtu_pkg::OPC_RETURN;
    stack_top_i = ~top;
    icr_wr_i = 1'b0;
    if (wr) exp_icr = d;
    if (k == 2) exp_icr[7] = 1'b1;
    if (k == 3) exp_acc = w[7:0];
    chk_bit(pc_load_o, k != 0);
    chk_bit(stack_pop_o, k != 0);
    chk_bit(busy_o, k != 0);
    if (k != 0) chk_pc(pc_o, top);
    chk_byte(accum_o, exp_acc);
    chk_byte(interrupt_control_reg_o, exp_icr);
    if (k != 0) begin
      for (int c = 2; c <= 4; c++) begin
        @(negedge clk_i);
        if (c == 2) insn_valid_i = 1'b0;
        chk_bit(pc_load_o, 1'b0);
        chk_bit(busy_o, c < 3);
      end
    end else begin
      @(negedge clk_i);
      chk_bit(busy_o, 1'b0);
    end
  endtask

  // wake-up: not before the sleep word completes, then vector or in-line
  task automatic do_wake(input logic [12:0] pn);
    sleeping_i = 1'b1;
    irq_pending_i = 1'b1;
    pc_next_i = pn;
    @(negedge clk_i);
    chk_bit(busy_o, 1'b0);
    sleep_done_i = 1'b1;
    @(negedge clk_i);
    sleeping_i = 1'b0;
    sleep_done_i = 1'b0;
    irq_pending_i = 1'b0;
    chk_bit(busy_o, 1'b1);
    @(negedge clk_i);
    chk_bit(wake_o, 1'b1);
    chk_bit(pc_load_o, 1'b1);
    chk_pc(pc_o, exp_icr[7] ? rtu_pkg::IRQ_VECTOR : pn);
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // main sequence: corner cases, then random words
  // ---------------------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk_i);
    rst_b_i = 1'b1;
    do_ret(rtu_pkg::OPC_RETURN, 13'h1FFF, 1'b0, 8'h00);
    do_ret({rtu_pkg::OPC_RETLIT_HI, 8'hFF}, 13'h0000, 1'b0, 8'h00);
    do_ret({rtu_pkg::OPC_RETLIT_HI, 8'h00}, 13'h0ABC, 1'b0, 8'h00);
    do_wake(13'h0123);
    do_ret(rtu_pkg::OPC_RETFROMIRQ, 13'h0555, 1'b1, 8'h7F);
    do_wake(13'h0321);
    for (int i = 0; i < 200; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      rnd_w = (lfsr_q[1:0] == 2'h0) ? rtu_pkg::OPC_RETURN :
              (lfsr_q[1:0] == 2'h1) ? rtu_pkg::OPC_RETFROMIRQ :
              (lfsr_q[1:0] == 2'h2) ? {rtu_pkg::OPC_RETLIT_HI, lfsr_q[15:8]} : lfsr_q[29:16];
      if (lfsr_q[4:2] == 3'h0) do_wake(lfsr_q[31:19]);
      else do_ret(rnd_w, lfsr_q[31:19], lfsr_q[5], lfsr_q[13:6]);
    end
    end_of_test;
  end

  // watchdog far beyond the expected run length
  initial begin
    #(4 * 20000);
    err_total++;
    end_of_test;
  end
endmodule
